// >>> logic/icap_top.sv
// Input capture module with its own 16-bit time base counter and capture buffer.
// Assumes APB access on REF_CLK_I, time base ticks and sync events as one-cycle
// pulses synchronous to REF_CLK_I, and a cascade partner wired to the CASC_* ports.
`timescale 1ns/1ps

// Overview of operation
// - Free-running counter counts on selected time base, wraps FFFFh to 0000h.
// - Each qualifying capture event writes the current counter value into the buffer unless it is full.
// - Buffer holds four captured values until software reads them.
// - Synchronous mode captures at once and clears counter on each sync event.
// - Trigger mode holds counter clear until a sync event, then runs.
// - Zero selector with trigger clear is free-running; nonzero picks sync or trigger.
// - Zero selector with trigger set waits for software to set trigger status.
// - Cascaded odd module gives low half; its rollovers advance the even counter.
// - Cascade acts only when both modules have cascade enable set.
// - Capture on rising edges, any edge, or every 4th or 16th rising edge.
// - Interrupt on every capture or only after a chosen number of captures.
// - Buffer-not-empty is set while data waits and clears after last read.
// - Even module of a pair runs free or synchronous by its selector, regardless of its trigger bit.
// - Odd module's interrupt count, trigger and capture settings govern the pair.
// - Cascaded synchronous pair stays in reset until the sync source is enabled.
// - Up to six time base sources and thirty-one sync sources are selectable.
// - Captures-per-interrupt codes 00..11 mean every first to fourth capture.
// - Time base code 111 selects the system clock, codes 000..100 the timers.
// - Read-only overflow flag is set by hardware on capture overflow.
module icap_top
   import icap_pkg::*;
#(
   parameter bit IS_ODD = 1'b1
) (
   input  wire logic                  REF_CLK_I,
   input  wire logic                  RST_N_I,
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [11:0]           PADDR_I,
   input  wire logic [31:0]           PWDATA_I,
   output logic      [31:0]           PRDATA_O,
   output logic                       PREADY_O,
   output logic                       PSLVERR_O,
   input  wire logic                  CAPTURE_INPUT_I,
   input  wire logic [TB_SRC_N-1:0]   TB_TICK_I,
   input  wire logic [SYNC_SRC_N-1:0] SYNC_EVT_I,
   input  wire logic [SYNC_SRC_N-1:0] SYNC_RUN_I,
   input  wire logic                  LOW_POWER_I,
   input  wire logic                  PARTNER_CASC_I,
   input  wire logic                  CASC_CARRY_I,
   input  wire logic                  CASC_CAPT_I,
   output logic                       CASC_CARRY_O,
   output logic                       CASC_CAPT_O,
   output logic                       CASC_EN_O,
   output logic                       IRQ_O
);
   localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

   // Configuration and status registers.
   logic [2:0]       tsel_reg;
   logic [1:0]       ici_reg;
   logic [2:0]       icm_reg;
   logic             ovf_reg;
   logic             casc_reg;
   logic             trig_reg;
   logic             tstat_reg;
   logic             tstat_next;
   logic [4:0]       sync_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [3:0]       pre_reg;
   logic [1:0]       irq_cnt_reg;
   logic             irq_reg;
   logic [31:0]      prdata_reg;
   logic             buf_armed_reg;

   // Decoded bus strobes.
   logic        setup;
   logic        access;
   logic        hit_ctrl1;
   logic        hit_ctrl2;
   logic        hit_buf;
   logic        mapped;
   logic        wr_ctrl1;
   logic        wr_ctrl2;
   logic        rd_buf;
   logic [31:0] rd_mux;

   // Derived operating state.
   logic     casc_act;
   logic     even_slave;
   logic     trig_eff;
   logic     mode_off;
   logic     tick;
   logic     inc;
   logic     sync_evt;
   logic     sync_live;
   logic     held;
   logic     sync_clr;
   icap_op_t op;

   // Capture path.
   logic rise;
   logic fall;
   logic edge_hit;
   logic own_cap;
   logic cap_fire;
   logic irq_hit;

   icap_fifo_if #(.W(CNT_W), .LVL_W(LVL_W)) fif ();

   icap_edge u_edge (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RST_N_I),
      .sig_i   (CAPTURE_INPUT_I),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   icap_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RST_N_I),
      .fif     (fif.store)
   );

   // APB decode; the slave never waits, so pready is high in every access phase.
   assign setup     = PSEL_I & ~PENABLE_I;
   assign access    = PSEL_I & PENABLE_I;
   assign hit_ctrl1 = (PADDR_I == ADDR_CTRL1);
   assign hit_ctrl2 = (PADDR_I == ADDR_CTRL2);
   assign hit_buf   = (PADDR_I == ADDR_BUF);
   assign mapped    = hit_ctrl1 | hit_ctrl2 | hit_buf;
   assign wr_ctrl1  = access & PWRITE_I & hit_ctrl1;
   assign wr_ctrl2  = access & PWRITE_I & hit_ctrl2;
   assign rd_buf    = access & ~PWRITE_I & hit_buf & buf_armed_reg;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access & ~mapped;
   assign PRDATA_O  = prdata_reg;

   // Read mux; buffer-not-empty is the live buffer state.
   always_comb begin
      rd_mux = '0;
      if (hit_ctrl1) begin
         rd_mux[C1_TSEL_LSB +: 3] = tsel_reg;
         rd_mux[C1_ICI_LSB +: 2]  = ici_reg;
         rd_mux[C1_OV_BIT]        = ovf_reg;
         rd_mux[C1_BNE_BIT]       = ~fif.empty;
         rd_mux[C1_ICM_LSB +: 3]  = icm_reg;
      end else if (hit_ctrl2) begin
         rd_mux[C2_CASC_BIT]      = casc_reg;
         rd_mux[C2_TRIG_BIT]      = trig_reg;
         rd_mux[C2_TSTAT_BIT]     = tstat_reg;
         rd_mux[C2_SYNC_LSB +: 5] = sync_reg;
      end else if (hit_buf && !fif.empty) begin
         rd_mux[CNT_W-1:0]        = fif.pop_data;
      end
   end

   // Read data is latched in the setup cycle so it is stable through the access phase.
   // The pop is armed there too, so a value pushed during setup is never popped unseen.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         prdata_reg    <= '0;
         buf_armed_reg <= 1'b0;
      end else if (setup && !PWRITE_I) begin
         prdata_reg    <= rd_mux;
         buf_armed_reg <= hit_buf & ~fif.empty;
      end
   end

   // Control fields; overflow is read-only and cleared only by disabling the mode.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         tsel_reg <= TSEL_RST;
         ici_reg  <= ICI_RST;
         icm_reg  <= ICM_RST;
         casc_reg <= 1'b0;
         trig_reg <= 1'b0;
         sync_reg <= SYNC_RST;
      end else begin
         if (wr_ctrl1) begin
            tsel_reg <= PWDATA_I[C1_TSEL_LSB +: 3];
            ici_reg  <= PWDATA_I[C1_ICI_LSB +: 2];
            icm_reg  <= PWDATA_I[C1_ICM_LSB +: 3];
         end
         if (wr_ctrl2) begin
            casc_reg <= PWDATA_I[C2_CASC_BIT];
            trig_reg <= PWDATA_I[C2_TRIG_BIT];
            sync_reg <= PWDATA_I[C2_SYNC_LSB +: 5];
         end
      end
   end

   // Pairing: the cascade acts only when both halves agree; the even half follows.
   assign casc_act   = casc_reg & PARTNER_CASC_I;
   assign even_slave = casc_act & ~IS_ODD;
   assign trig_eff   = trig_reg & ~even_slave;
   assign CASC_EN_O  = casc_reg;
   assign mode_off   = (icm_reg == ICM_OFF);

   // Operating mode from selector and trigger bit.
   always_comb begin
      if (sync_reg == 5'h00) begin
         op = trig_eff ? ICAP_SWTRIG : ICAP_FREE;
      end else begin
         op = trig_eff ? ICAP_TRIG : ICAP_SYNC;
      end
   end

   // Time base and sync source selection; unused codes give no tick.
   assign tick      = (tsel_reg == TSEL_SYS) ? 1'b1 :
                      (tsel_reg <= TSEL_LAST) ? TB_TICK_I[tsel_reg] : 1'b0;
   assign sync_evt  = (sync_reg != 5'h00) & SYNC_EVT_I[sync_reg];
   assign sync_live = SYNC_RUN_I[sync_reg];
   assign inc       = even_slave ? CASC_CARRY_I : tick;

   // The counter is held clear while disabled, untriggered, or waiting on the sync source.
   always_comb begin
      held = mode_off;
      case (op)
         ICAP_TRIG, ICAP_SWTRIG: held = mode_off | ~tstat_reg;
         ICAP_SYNC:              held = mode_off | (casc_act & ~sync_live);
         ICAP_FREE:              held = mode_off;
         default:                held = 1'b1;
      endcase
   end
   assign sync_clr = (op == ICAP_SYNC) & sync_evt;

   // Counter update; the 16-bit sum wraps from the maximum back to zero.
   always_comb begin
      cnt_next = cnt_reg;
      if (held || sync_clr) begin
         cnt_next = '0;
      end else if (inc) begin
         cnt_next = CNT_W'(cnt_reg + 1'b1);
      end
   end
   assign CASC_CARRY_O = ~held & ~sync_clr & inc & (cnt_reg == CNT_MAX);

   // Trigger status: a sync event sets it and wins over a software write.
   always_comb begin
      tstat_next = tstat_reg;
      if (op == ICAP_TRIG && sync_evt) begin
         tstat_next = 1'b1;
      end else if (wr_ctrl2) begin
         tstat_next = PWDATA_I[C2_TSTAT_BIT];
      end
   end

   // Counter, trigger status and interrupt output registers.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         cnt_reg   <= '0;
         tstat_reg <= 1'b0;
         irq_reg   <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         tstat_reg <= tstat_next;
         irq_reg   <= irq_hit;
      end
   end

   // Edge qualification per capture mode; wake mode never stores a value.
   always_comb begin
      case (icm_reg)
         ICM_EVERY: edge_hit = rise | fall;
         ICM_FALL:  edge_hit = fall;
         ICM_RISE:  edge_hit = rise;
         ICM_PRE4:  edge_hit = rise & (pre_reg[1:0] == PRE4_LAST[1:0]);
         ICM_PRE16: edge_hit = rise & (pre_reg == PRE16_LAST);
         default:   edge_hit = 1'b0;
      endcase
   end

   // Prescaler counts rising edges and restarts whenever a non-prescaled mode is chosen.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         pre_reg <= '0;
      end else if (icm_reg != ICM_PRE4 && icm_reg != ICM_PRE16) begin
         pre_reg <= '0;
      end else if (rise) begin
         pre_reg <= 4'(pre_reg + 1'b1);
      end
   end

   // The odd half decides when the pair captures, so both buffers stay in step.
   assign own_cap     = ~held & edge_hit;
   assign cap_fire    = even_slave ? CASC_CAPT_I : own_cap;
   assign CASC_CAPT_O = own_cap;
   assign fif.push      = cap_fire & ~fif.full;
   assign fif.push_data = cnt_reg;
   assign fif.pop       = rd_buf;

   // Overflow: set on a dropped capture; the set wins over the clear by disabling.
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         ovf_reg <= 1'b0;
      end else if (cap_fire && fif.full) begin
         ovf_reg <= 1'b1;
      end else if (mode_off) begin
         ovf_reg <= 1'b0;
      end
   end

   // Interrupt pacing; the even half of a pair stays quiet because the odd half reports.
   assign irq_hit = even_slave ? 1'b0 :
                    (icm_reg == ICM_WAKE) ? (rise & LOW_POWER_I) :
                    (cap_fire & (irq_cnt_reg >= ici_reg));

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         irq_cnt_reg <= '0;
      end else if (mode_off || irq_hit) begin
         irq_cnt_reg <= '0;
      end else if (cap_fire) begin
         irq_cnt_reg <= 2'(irq_cnt_reg + 1'b1);
      end
   end
   assign IRQ_O = irq_reg;

   // Checks on the behaviour above.
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   AST_WRAP: assert property (!held && !sync_clr && inc && cnt_reg == CNT_MAX |=> cnt_reg == '0)
      else $error("Counter did not wrap to zero.");
   AST_FREE_INC: assert property (op == ICAP_FREE && !mode_off && inc |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("Free-running counter did not advance.");
   AST_PUSH_VAL: assert property (cap_fire && !fif.full && !fif.pop && fif.empty |=> fif.pop_data == $past(cnt_reg))
      else $error("Captured value differs from counter.");
   AST_DEPTH: assert property (fif.level <= LVL_W'(FIFO_DEPTH))
      else $error("Buffer level beyond its depth.");
   AST_SYNC_CLR: assert property (op == ICAP_SYNC && sync_evt |=> cnt_reg == '0)
      else $error("Sync event did not clear the counter.");
   AST_TRIG_HOLD: assert property ((op == ICAP_TRIG || op == ICAP_SWTRIG) && !tstat_reg && !sync_evt
                                   |=> cnt_reg == '0 && !$past(own_cap))
      else $error("Counter ran before trigger.");
   AST_TRIG_SET: assert property (op == ICAP_TRIG && sync_evt |=> tstat_reg)
      else $error("Trigger event did not set status.");
   AST_PRE4: assert property (icm_reg == ICM_PRE4 && !held && rise && pre_reg[1:0] != 2'h3 |-> !own_cap)
      else $error("Prescaled capture on wrong edge.");
   AST_IRQ_EVERY: assert property (ici_reg == 2'h0 && icm_reg != ICM_WAKE && cap_fire && !even_slave |=> IRQ_O)
      else $error("Missing interrupt for capture.");
   AST_BNE_CLR: assert property (fif.level == 3'h1 && rd_buf && !fif.push |=> fif.empty [*1] ##0 !rd_mux[C1_BNE_BIT] || !hit_ctrl1)
      else $error("Not-empty status stuck after last read.");
   AST_OVF: assert property (cap_fire && fif.full && !fif.pop |=> ovf_reg && fif.full)
      else $error("Overflow not flagged on full buffer.");
   AST_CASC: assert property (!casc_act |-> !even_slave && inc == tick)
      else $error("Unpaired module does not count on its own time base.");
endmodule // icap_top

// >>> common/icap_pkg.sv
// Shared constants for the input capture block: register map, field positions,
// reset values, mode encodings and the operating-mode type.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
package icap_pkg;

   // Counter and buffer geometry.
   localparam int CNT_W      = 16;
   localparam int FIFO_DEPTH = 4;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   // Register byte addresses.
   localparam logic [11:0] ADDR_CTRL1 = 12'h000;
   localparam logic [11:0] ADDR_CTRL2 = 12'h004;
   localparam logic [11:0] ADDR_BUF   = 12'h008;

   // Field positions of capture_control_one.
   localparam int C1_TSEL_LSB = 10;
   localparam int C1_ICI_LSB  = 5;
   localparam int C1_OV_BIT   = 4;
   localparam int C1_BNE_BIT  = 3;
   localparam int C1_ICM_LSB  = 0;

   // Field positions of capture_control_two.
   localparam int C2_CASC_BIT  = 8;
   localparam int C2_TRIG_BIT  = 7;
   localparam int C2_TSTAT_BIT = 6;
   localparam int C2_SYNC_LSB  = 0;

   // Values after reset.
   localparam logic [2:0] TSEL_RST  = 3'h0;
   localparam logic [1:0] ICI_RST   = 2'h0;
   localparam logic [2:0] ICM_RST   = 3'h0;
   localparam logic [4:0] SYNC_RST  = 5'h0D;

   // Capture mode encodings.
   localparam logic [2:0] ICM_OFF   = 3'h0;
   localparam logic [2:0] ICM_EVERY = 3'h1;
   localparam logic [2:0] ICM_FALL  = 3'h2;
   localparam logic [2:0] ICM_RISE  = 3'h3;
   localparam logic [2:0] ICM_PRE4  = 3'h4;
   localparam logic [2:0] ICM_PRE16 = 3'h5;
   localparam logic [2:0] ICM_WAKE  = 3'h7;

   // Prescaler terminal counts for every 4th and every 16th rising edge.
   localparam logic [3:0] PRE4_LAST  = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;

   // Time base selector codes; the five lowest codes map to tick inputs, code 7 to the system clock.
   localparam logic [2:0] TSEL_SYS   = 3'h7;
   localparam logic [2:0] TSEL_LAST  = 3'h4;
   localparam int         TB_SRC_N   = 5;
   localparam int         SYNC_SRC_N = 32;

   typedef enum logic [1:0] {ICAP_FREE, ICAP_SYNC, ICAP_TRIG, ICAP_SWTRIG} icap_op_t;

endpackage

// >>> common/icap_fifo_if.sv
// Carrier between the capture control logic and its value buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface icap_fifo_if #(
   parameter int W     = 16,
   parameter int LVL_W = 3
);
   logic             push;
   logic [W-1:0]     push_data;
   logic             pop;
   logic [W-1:0]     pop_data;
   logic             full;
   logic             empty;
   logic [LVL_W-1:0] level;

   modport prod  (output push, push_data, pop, input pop_data, full, empty, level);
   modport store (input push, push_data, pop, output pop_data, full, empty, level);
endinterface

// >>> logic/icap_fifo.sv
// Buffer of captured counter values, first in first out.
// Assumes the producer never pushes when full nor pops when empty.
`timescale 1ns/1ps
module icap_fifo #(
   parameter int DEPTH = 4
) (
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   icap_fifo_if.store  fif
);
   localparam int AW = $clog2(DEPTH);

   logic [fif.W-1:0]     mem [DEPTH];
   logic [AW-1:0]        wr_ptr_reg;
   logic [AW-1:0]        rd_ptr_reg;
   logic [fif.LVL_W-1:0] level_reg;
   logic                 do_push;
   logic                 do_pop;

   // Guard the strobes so a stray access cannot corrupt the pointers.
   assign do_push      = fif.push & ~fif.full;
   assign do_pop       = fif.pop & ~fif.empty;
   assign fif.full     = (level_reg == fif.LVL_W'(DEPTH));
   assign fif.empty    = (level_reg == '0);
   assign fif.level    = level_reg;
   assign fif.pop_data = mem[rd_ptr_reg];

   // Storage array has no reset; only the pointers and the level need a defined start.
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= fif.push_data;
      end
   end

   // Pointer and level bookkeeping.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         if (do_push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
         if (do_pop)  rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
         level_reg <= fif.LVL_W'(level_reg + do_push - do_pop);
      end
   end
endmodule // icap_fifo

// >>> logic/icap_edge.sv
// Edge detector for the capture input.
// Assumes the input is already synchronous to the clock.
`timescale 1ns/1ps
module icap_edge (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic sig_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic prev_reg;

   // Previous sample of the pin.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= sig_i;
      end
   end

   // Edges are one-cycle pulses in the cycle the new level is seen.
   assign rise_o = sig_i & ~prev_reg;
   assign fall_o = ~sig_i & prev_reg;
endmodule // icap_edge

// >>> sim/icap_pulse_gen.sv
// Behavioural model of the pulse source that drives the capture input pin.
// Assumes the bench asks for a burst with a one-cycle start strobe on clk_i.
`timescale 1ns/1ps
module icap_pulse_gen (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       start_i,
   input  wire logic [4:0] count_i,
   output logic            pin_o,
   output logic            busy_o
);
   logic [4:0] left_reg;
   logic [1:0] phase_reg;

   // Pulses are two cycles high and two low, so every transition is seen.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || start_i) begin
         left_reg  <= rst_n_i ? count_i : 5'h00;
         phase_reg <= 2'h0;
         pin_o     <= 1'b0;
      end else if (left_reg != 5'h00) begin
         phase_reg <= phase_reg + 2'h1;
         pin_o     <= (phase_reg == 2'h1) ? 1'b1 : ((phase_reg == 2'h3) ? 1'b0 : pin_o);
         left_reg  <= (phase_reg == 2'h3) ? left_reg - 5'h01 : left_reg;
      end
   end

   assign busy_o = (left_reg != 5'h00); // Low again once the last pulse has ended.
endmodule // icap_pulse_gen

// >>> sim/tb_input_capture_with_timer.sv
// Self-checking bench for one capture module: APB register checks and capture scenarios.
// Assumes a lone odd module with no cascade partner; ticks and sync pulses come from here.
`timescale 1ns/1ps
module tb_input_capture_with_timer
   import icap_pkg::*;
;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
   logic [11:0]           paddr = 12'h000;
   logic [31:0]           pwdata = 32'h0, prdata, q;
   logic                  pready, pslverr, pin, busy, irq, e, carry, capt, casc_en;
   logic                  lowp = 1'b0;
   logic [4:0]            npulse = 5'h00;
   logic [TB_SRC_N-1:0]   tick = '0;
   logic [SYNC_SRC_N-1:0] sync = '0;
   int                    n_fail = 0, n_tests = 0, cyc = 0, n_irq = 0, n_carry = 0, n_capt = 0;
   logic [31:0]           c2v[3] = '{32'h0, 32'h1, 32'h82};
   int                    pre[3] = '{5, 5, 3}, ev[3] = '{0, 1, 2}, post[3] = '{0, 2, 4}, ex[3] = '{5, 2, 4};
   logic [2:0]            md[6] = '{ICM_EVERY, ICM_FALL, ICM_RISE, ICM_PRE4, ICM_PRE16, ICM_OFF};
   int                    np[6] = '{4, 4, 3, 7, 16, 2}, en[6] = '{4, 4, 3, 1, 1, 0}, eo[6] = '{1, 0, 0, 0, 0, 0};
   int                    ec[6] = '{8, 4, 3, 1, 1, 0};

   icap_top #(.IS_ODD(1'b1)) icap_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CAPTURE_INPUT_I(pin), .TB_TICK_I(tick), .SYNC_EVT_I(sync), .SYNC_RUN_I('1),
      .LOW_POWER_I(lowp), .PARTNER_CASC_I(1'b0), .CASC_CARRY_I(1'b0), .CASC_CAPT_I(1'b0),
      .CASC_CARRY_O(carry), .CASC_CAPT_O(capt), .CASC_EN_O(casc_en), .IRQ_O(irq));
   icap_pulse_gen icap_pulse_gen_i (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .count_i(npulse),
      .pin_o(pin), .busy_o(busy));

   // Free-running clock, 5 ns period.
   initial begin
      forever #2.5 clk = ~clk;
   end

   // Cycle count for the hang limit, and tallies of interrupt, rollover and capture pulses.
   // The ceiling leaves room for one full counter wrap on the system clock time base.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) n_irq <= n_irq + 1;
      if (carry === 1'b1) n_carry <= n_carry + 1;
      if (capt === 1'b1) n_capt <= n_capt + 1;
      if (cyc == 90000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   task end_sim;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at an edge.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task ticks(input int n);
      repeat (n) begin
         @(posedge clk); tick[0] <= 1'b1;
         @(posedge clk); tick[0] <= 1'b0;
      end
   endtask

   task syncp(input int s);
      @(posedge clk); sync[s] <= 1'b1;
      @(posedge clk); sync[s] <= 1'b0;
   endtask

   // Pulses are asked of the pulse generator; two idle cycles let the push land.
   task pulses(input int n);
      @(posedge clk); start <= 1'b1; npulse <= n[4:0];
      @(posedge clk); start <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   // Reads the buffer until not-empty clears, bounded in case it never does.
   task drain(output int n);
      n = 0;
      apb(1'b0, ADDR_CTRL1, 32'h0);
      while (q[C1_BNE_BIT] === 1'b1 && n < 6) begin
         apb(1'b0, ADDR_BUF, 32'h0);
         n++;
         apb(1'b0, ADDR_CTRL1, 32'h0);
      end
   endtask

   // Mode off and drained first, then source, then mode, as software must.
   task cfg(input logic [31:0] c2, input logic [31:0] c1);
      int n;
      apb(1'b1, ADDR_CTRL1, 32'h0);
      drain(n);
      apb(1'b1, ADDR_CTRL2, c2);
      apb(1'b1, ADDR_CTRL1, c1);
   endtask

   // Main sequence: registers, captured values, capture modes, interrupt counts.
   initial begin : main
      int n, k;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_CTRL1, 32'h0); chk("ctrl1 reset", 32'h0, q);
      apb(1'b0, ADDR_CTRL2, 32'h0); chk("ctrl2 reset", 32'h0000000D, q);
      chk("cascade enable reset", 32'h0, {31'h0, casc_en});
      apb(1'b0, 12'h00C, 32'h0); chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      apb(1'b0, ADDR_BUF, 32'h0); chk("empty buffer", 32'h0, q);
      apb(1'b1, ADDR_CTRL1, 32'h18);
      apb(1'b0, ADDR_CTRL1, 32'h0); chk("status read only", 32'h0, q);
      apb(1'b1, ADDR_CTRL2, 32'h0000010D);
      apb(1'b0, ADDR_CTRL2, 32'h0); chk("cascade bit", 32'h0000010D, q);
      chk("cascade enable out", 32'h1, {31'h0, casc_en});
      for (int i = 0; i < 3; i++) begin
         cfg(c2v[i], {29'h0, ICM_RISE});
         ticks(pre[i]);
         if (ev[i] != 0) syncp(ev[i]);
         ticks(post[i]);
         pulses(1);
         apb(1'b0, ADDR_BUF, 32'h0); chk("capture value", ex[i], q);
      end
      cfg(32'h80, {29'h0, ICM_RISE});
      ticks(3);
      pulses(1);
      drain(n); chk("sw trigger blocked", 32'h0, n);
      apb(1'b1, ADDR_CTRL2, 32'hC0);
      ticks(2);
      pulses(1);
      apb(1'b0, ADDR_BUF, 32'h0); chk("sw trigger value", 32'h2, q);
      for (int i = 0; i < 6; i++) begin
         cfg(32'h0, {29'h0, md[i]});
         k = n_capt;
         pulses(np[i]);
         chk("capture events", ec[i], n_capt - k);
         apb(1'b0, ADDR_CTRL1, 32'h0); chk("overflow", eo[i], {31'h0, q[C1_OV_BIT]});
         drain(n); chk("captures", en[i], n);
      end
      for (int i = 0; i < 4; i++) begin
         cfg(32'h0, (i << C1_ICI_LSB) | ICM_RISE);
         k = n_irq;
         pulses(4);
         chk("interrupts", 4 / (i + 1), n_irq - k);
      end
      // Wake mode interrupts only while in low power and never stores a value.
      for (int i = 0; i < 2; i++) begin
         lowp <= (i == 0);
         cfg(32'h0, {29'h0, ICM_WAKE});
         k = n_irq;
         pulses(3);
         chk("wake interrupts", 3 * (1 - i), n_irq - k);
         drain(n); chk("wake captures", 32'h0, n);
      end
      // One full wrap on the system clock time base gives exactly one rollover pulse.
      cfg(32'h0, ({29'h0, TSEL_SYS} << C1_TSEL_LSB) | ICM_RISE);
      k = n_carry;
      repeat (65540) @(posedge clk);
      chk("rollovers", 32'h1, n_carry - k);
      end_sim();
   end
endmodule // tb_input_capture_with_timer
